//--- src/adc_conversion_sequencer.sv
// Successive-approximation conversion sequencer with its register file
// What this block does
// - On completion load result pair, clear go flag, set done flag.
// - A go-started conversion lasts thirteen conversion clock periods unless aborted.
// - Clearing go mid-conversion aborts; the partial result is stored unless still settling.
// - After an early halt past the settling period unconverted result bits read as zero.
// - Setting power-on and go in one write clears go automatically.
// - Special event with mode 1011b and power on sets go, clears timer count.
// - With power off the special event is ignored but still clears timer count.
// - Reset restores registers, powers converter off, aborts any conversion.
// - Non-power-on reset keeps the result pair; power-on reset clears it to zero.
// - Acquisition is unchanged by resolution; the conversion also stays at CONV_TADS periods.
// - A full conversion yields a 12-bit result.
// - Conversion period is a division of the oscillator clock, including 32.
// - Pin analog-select register switches pins between analog and digital use.
// - Raise converter interrupt at completion when enabled; accept special event start.
`timescale 1ns/1ps
module adc_conversion_sequencer #(
    parameter int RES_W  = adc_seq_pkg::RESULT_W,
    parameter int NPINS  = 6
) (
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  por_n,
    input  wire logic                  clk_en,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // Compare unit
    input  wire logic [3:0]            compare_mode_field,
    input  wire logic                  special_event,
    output logic                       timer1_clear,
    // Analog core
    output adc_seq_pkg::core_req_t     core_req,
    input  wire logic                  core_compare,
    // Pins and interrupt
    output logic      [NPINS-1:0]      pin_analog_select,
    output logic                       conv_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and wires

    adc_seq_pkg::seq_state_t state_reg;
    adc_seq_pkg::seq_state_t state_next;

    logic [7:0]        conv_control_reg;
    logic [7:0]        conv_config_reg;
    logic [7:0]        analog_reg;
    logic [RES_W-1:0]  result_pair_reg;
    logic [RES_W-1:0]  sar_reg;
    logic [RES_W-1:0]  bit_ptr_reg;
    logic [3:0]        tad_cnt_reg;
    logic              done_reg;
    logic              irq_en_reg;
    logic              rd_pending_reg;
    logic [7:0]        rd_data_reg;

    logic              tick;
    logic              wr_ctl;
    logic              go_set_sw;
    logic              go_clr_sw;
    logic              power_on;
    logic              power_rise;
    logic              trig_start;
    logic              start;
    logic              finish;
    logic              abort;
    logic              busy;
    logic [RES_W-1:0]  sar_decided;
    logic [RES_W-1:0]  partial;
    logic [7:0]        read_mux;

    function automatic logic hit(input logic [7:0] a, input logic [2:0] off);
        hit = (a == {5'h00, off});
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    assign busy       = (state_reg != adc_seq_pkg::SEQ_IDLE);
    assign wr_ctl     = reg_wr && hit(reg_addr, adc_seq_pkg::OFF_CONTROL);
    assign power_on   = conv_control_reg[adc_seq_pkg::CTL_POWER_BIT];
    assign power_rise = wr_ctl && reg_wdata[adc_seq_pkg::CTL_POWER_BIT] && !power_on;
    assign go_set_sw  = wr_ctl && reg_wdata[adc_seq_pkg::CTL_GO_BIT] && !power_rise
                        && reg_wdata[adc_seq_pkg::CTL_POWER_BIT];
    assign go_clr_sw  = wr_ctl && !reg_wdata[adc_seq_pkg::CTL_GO_BIT] && busy;
    assign trig_start = special_event && power_on
                        && (compare_mode_field == adc_seq_pkg::SPECIAL_EVENT_MODE);
    assign start      = !busy && (go_set_sw || trig_start);
    assign timer1_clear = special_event && (compare_mode_field == adc_seq_pkg::SPECIAL_EVENT_MODE);
    assign abort  = go_clr_sw || (busy && wr_ctl && !reg_wdata[adc_seq_pkg::CTL_POWER_BIT]);
    assign finish = busy && tick && (tad_cnt_reg == 4'(adc_seq_pkg::CONV_TADS - 1)) && !abort;

    // decide current bit on each period, MSB first
    assign sar_decided = core_compare ? sar_reg : (sar_reg & ~bit_ptr_reg);
    // bits not yet converted are zero
    assign partial     = sar_reg & ~bit_ptr_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            adc_seq_pkg::SEQ_IDLE:   if (start) state_next = adc_seq_pkg::SEQ_SETTLE;
            // one settling period, independent of resolution
            adc_seq_pkg::SEQ_SETTLE: if (abort) state_next = adc_seq_pkg::SEQ_IDLE;
                                     else if (tick) state_next = adc_seq_pkg::SEQ_BITS;
            adc_seq_pkg::SEQ_BITS:   if (abort || finish) state_next = adc_seq_pkg::SEQ_IDLE;
        endcase
    end

    tad_divider #(
        .CNT_W (7)
    ) u_div (
        .clk    (clk),
        .resetn (resetn),
        .clk_en (clk_en),
        .run    (busy),
        .sel    (conv_control_reg[adc_seq_pkg::CTL_CLK_LSB +: adc_seq_pkg::CTL_CLK_W]),
        .tick   (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg   <= adc_seq_pkg::SEQ_IDLE;
            tad_cnt_reg <= 4'h0;
            sar_reg     <= '0;
            bit_ptr_reg <= '0;
        end else if (clk_en) begin
            state_reg <= state_next;
            if (start) begin
                tad_cnt_reg <= 4'h0;
                sar_reg     <= {1'b1, {(RES_W-1){1'b0}}};
                bit_ptr_reg <= {1'b1, {(RES_W-1){1'b0}}};
            end else if (busy && tick) begin
                tad_cnt_reg <= tad_cnt_reg + 4'h1;
                if (state_reg == adc_seq_pkg::SEQ_BITS && bit_ptr_reg != '0) begin
                    sar_reg     <= sar_decided | (bit_ptr_reg >> 1);
                    bit_ptr_reg <= bit_ptr_reg >> 1;
                end
            end
        end
    end

    // result pair reset only by power-on
    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            result_pair_reg <= '0;
        end else if (clk_en) begin
            if (finish) begin
                // The last bit is decided in the finishing cycle itself
                result_pair_reg <= sar_decided;
            end else if (abort && state_reg == adc_seq_pkg::SEQ_BITS) begin
                result_pair_reg <= partial;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_control_reg <= adc_seq_pkg::CONTROL_RST;
            conv_config_reg  <= adc_seq_pkg::CONFIG_RST;
            analog_reg       <= adc_seq_pkg::ANALOG_RST;
            done_reg         <= 1'b0;
            irq_en_reg       <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctl) begin
                conv_control_reg <= reg_wdata & ~(8'h01 << adc_seq_pkg::CTL_GO_BIT);
            end
            // go set by trigger or software
            if (start) begin
                conv_control_reg[adc_seq_pkg::CTL_GO_BIT] <= 1'b1;
            end else if (finish || abort) begin
                conv_control_reg[adc_seq_pkg::CTL_GO_BIT] <= 1'b0;
            // Go stays up while running, even across a non-aborting control write
            end else if (busy) begin
                conv_control_reg[adc_seq_pkg::CTL_GO_BIT] <= 1'b1;
            end
            if (reg_wr && hit(reg_addr, adc_seq_pkg::OFF_CONFIG)) begin
                conv_config_reg <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, adc_seq_pkg::OFF_ANALOG)) begin
                analog_reg <= reg_wdata;
            end
            if (reg_wr && hit(reg_addr, adc_seq_pkg::OFF_FLAGS)) begin
                irq_en_reg <= reg_wdata[adc_seq_pkg::FLG_IRQEN_BIT];
            end
            if (finish) begin
                done_reg <= 1'b1;
            end else if (reg_wr && hit(reg_addr, adc_seq_pkg::OFF_FLAGS)) begin
                done_reg <= reg_wdata[adc_seq_pkg::FLG_DONE_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path and outputs

    // Right-justified result: low byte holds bits 7:0, high byte bits 11:8
    assign read_mux =
        hit(reg_addr, adc_seq_pkg::OFF_CONTROL) ? conv_control_reg :
        hit(reg_addr, adc_seq_pkg::OFF_CONFIG)  ? conv_config_reg :
        hit(reg_addr, adc_seq_pkg::OFF_ANALOG)  ? analog_reg :
        hit(reg_addr, adc_seq_pkg::OFF_RES_HI)  ? {{(16-RES_W){1'b0}}, result_pair_reg[RES_W-1:8]} :
        hit(reg_addr, adc_seq_pkg::OFF_RES_LO)  ? result_pair_reg[7:0] :
        hit(reg_addr, adc_seq_pkg::OFF_FLAGS)   ? {6'h00, irq_en_reg, done_reg} : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_reg    <= 8'h00;
            rd_pending_reg <= 1'b0;
        end else if (clk_en) begin
            rd_pending_reg <= reg_rd;
            rd_data_reg    <= reg_rd ? read_mux : 8'h00;
        end
    end

    assign reg_rdata = rd_pending_reg ? rd_data_reg : 8'h00;

    assign conv_irq = done_reg && irq_en_reg;

    assign pin_analog_select = analog_reg[NPINS-1:0];

    assign core_req.sample  = (state_reg == adc_seq_pkg::SEQ_SETTLE);
    assign core_req.decide  = (state_reg == adc_seq_pkg::SEQ_BITS) && tick;
    assign core_req.trial   = sar_reg;
    assign core_req.channel = conv_control_reg[adc_seq_pkg::CTL_CHAN_LSB +: adc_seq_pkg::CTL_CHAN_W];

endmodule

//--- src/adc_seq_pkg.sv
// Package: register map, field layout, reset values and timing for the conversion sequencer
package adc_seq_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] OFF_CONTROL = 3'h0;
    localparam logic [2:0] OFF_CONFIG  = 3'h1;
    localparam logic [2:0] OFF_ANALOG  = 3'h2;
    localparam logic [2:0] OFF_RES_HI  = 3'h3;
    localparam logic [2:0] OFF_RES_LO  = 3'h4;
    localparam logic [2:0] OFF_FLAGS   = 3'h5;

    // Control register fields
    localparam int CTL_POWER_BIT = 0;
    localparam int CTL_GO_BIT    = 2;
    localparam int CTL_CHAN_LSB  = 3;
    localparam int CTL_CHAN_W    = 3;
    localparam int CTL_CLK_LSB   = 6;
    localparam int CTL_CLK_W     = 2;

    // Flags register fields
    localparam int FLG_DONE_BIT  = 0;
    localparam int FLG_IRQEN_BIT = 1;

    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] CONFIG_RST  = 8'h00;
    localparam logic [7:0] ANALOG_RST  = 8'h3F;

    // Compare unit mode that selects the special event trigger
    localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;

    // Result width, conversion length and bits of a full conversion
    localparam int RESULT_W    = 12;
    localparam int CONV_TADS   = 13;

    // Conversion clock divisors in oscillator periods, selected by the clock field
    localparam int TAD_DIV_0 = 2;
    localparam int TAD_DIV_1 = 8;
    localparam int TAD_DIV_2 = 32;
    localparam int TAD_DIV_3 = 64;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_SETTLE,
        SEQ_BITS
    } seq_state_t;

    // Request to the analog core, and a register port request
    typedef struct packed {
        logic                  sample;
        logic                  decide;
        logic [RESULT_W-1:0]   trial;
        logic [2:0]            channel;
    } core_req_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

//--- src/tad_divider.sv
// Conversion clock divider: one tick every selected number of oscillator periods
`timescale 1ns/1ps
module tad_divider #(
    parameter int CNT_W = 7
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // Control
    input  wire logic        run,
    input  wire logic [1:0]  sel,
    // Tick
    output logic             tick
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] limit;
    logic             at_limit;

    assign limit = (sel == 2'h0) ? CNT_W'(adc_seq_pkg::TAD_DIV_0 - 1) :
                   (sel == 2'h1) ? CNT_W'(adc_seq_pkg::TAD_DIV_1 - 1) :
                   (sel == 2'h2) ? CNT_W'(adc_seq_pkg::TAD_DIV_2 - 1) :
                                   CNT_W'(adc_seq_pkg::TAD_DIV_3 - 1);
    assign at_limit = (count_reg == limit);
    assign tick     = run && at_limit;

    // Restart from zero on every start so the first period is whole
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
        end else if (clk_en) begin
            count_reg <= (!run || at_limit) ? '0 : count_reg + CNT_W'(1);
        end
    end

endmodule

//--- sim/adc_seq_props.sv
// Checker: port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module adc_seq_props #(
    parameter int NPINS = 6
) (
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire logic                   reg_rd,
    input wire logic [7:0]             reg_rdata,
    input wire logic [3:0]             compare_mode_field,
    input wire logic                   special_event,
    input wire logic                   timer1_clear,
    input wire adc_seq_pkg::core_req_t core_req,
    input wire logic [NPINS-1:0]       pin_analog_select,
    input wire logic                   conv_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_trig_clear: assert property (
        timer1_clear == (special_event && compare_mode_field == adc_seq_pkg::SPECIAL_EVENT_MODE))
        else $error("timer clear does not follow the special event");
    chk_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data outside its cycle");
    chk_analog_reset: assert property (
        $rose(resetn) |-> pin_analog_select == {NPINS{1'b1}}) else $error("pin select not at reset value");
    chk_reset_quiet: assert property (
        $rose(resetn) |-> !conv_irq && !core_req.sample) else $error("activity right after reset");
    chk_decide_pulse: assert property (
        core_req.decide |=> !core_req.decide) else $error("decide longer than one cycle");
    chk_settle_quiet: assert property (
        core_req.sample |-> !core_req.decide) else $error("decision during settle");
    chk_settle_len: assert property (
        $rose(core_req.sample) |-> core_req.sample [*2]) else $error("settle shorter than one period");
    chk_settle_bound: assert property (
        $rose(core_req.sample) |-> ##[2:65] !core_req.sample) else $error("settle longer than one period");

    cover property ($rose(core_req.sample));
    cover property ($rose(conv_irq));
    cover property (timer1_clear);
endmodule

bind adc_conversion_sequencer adc_seq_props #(.NPINS(NPINS)) u_props (
    .clk(clk), .resetn(resetn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .compare_mode_field(compare_mode_field), .special_event(special_event),
    .timer1_clear(timer1_clear), .core_req(core_req),
    .pin_analog_select(pin_analog_select), .conv_irq(conv_irq));

//--- sim/tb_top.sv
// Testbench: random and corner scenarios for the conversion sequencer
`timescale 1ns/1ps
module tb_top;
    logic                   clk = 1'b0, resetn = 1'b0, por_n = 1'b0, clk_en = 1'b1;
    logic [7:0]             reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rdv;
    logic                   reg_wr = 1'b0, reg_rd = 1'b0, special_event = 1'b0;
    logic [3:0]             compare_mode_field = 4'h0, dcnt = 4'h0;
    logic                   timer1_clear, conv_irq;
    logic [5:0]             pin_analog_select;
    adc_seq_pkg::core_req_t core_req;
    logic [11:0]            pat = 12'h000, rr;
    int                     miscompares = 0, num_checks = 0, seed = 5, n;
    // Core answers follow a random pattern, MSB first
    wire core_compare = (dcnt < 4'hC) ? pat[4'hB - dcnt] : 1'b0;

    always #2.5 clk = ~clk;
    // Decision count restarts in every settle period, so one process drives it
    always @(posedge clk) dcnt <= core_req.sample ? 4'h0 : dcnt + 4'(core_req.decide);

    adc_conversion_sequencer DUT (.clk(clk), .resetn(resetn), .por_n(por_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .compare_mode_field(compare_mode_field), .special_event(special_event), .timer1_clear(timer1_clear),
        .core_req(core_req), .core_compare(core_compare), .pin_analog_select(pin_analog_select),
        .conv_irq(conv_irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk); reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk); reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
    endtask
    task automatic rd_res;
        rd(8'(adc_seq_pkg::OFF_RES_HI)); rr[11:8] = rdv[3:0];
        rd(8'(adc_seq_pkg::OFF_RES_LO)); rr[7:0] = rdv;
    endtask
    // Bounded wait; running out ends the run as a failure
    task automatic wait_irq(output int c);
        c = 0;
        while (conv_irq !== 1'b1 && c < 1000) begin @(posedge clk); #1 c++; end
        if (c >= 1000) begin miscompares++; complete_run(); end
    endtask
    function automatic int divf(input logic [1:0] s);
        return s == 0 ? adc_seq_pkg::TAD_DIV_0 : s == 1 ? adc_seq_pkg::TAD_DIV_1 :
               s == 2 ? adc_seq_pkg::TAD_DIV_2 : adc_seq_pkg::TAD_DIV_3;
    endfunction
    // One conversion with clock select s; ab > 0 aborts after ab decisions
    task automatic conv(input logic [1:0] s, input int ab);
        logic [7:0] c;
        int         cy;
        c = {s, 3'b001, 3'b001};
        wr(8'h05, 8'h02);
        wr(8'h00, c);
        @(posedge clk); pat <= 12'($random(seed));
        wr(8'h00, c | 8'h04);
        if (ab > 0) begin
            cy = 0;
            while (dcnt != 4'(ab) && cy < 1000) begin @(posedge clk); #1 cy++; end
            if (cy >= 1000) begin miscompares++; complete_run(); end
            wr(8'h00, c);
            rd_res; chk("partial", pat & (12'hFFF << (12 - ab)), rr);
        end else begin
            wait_irq(cy);
            chk("length", 1, cy >= 13 * divf(s) - 1 && cy <= 13 * divf(s) + 2);
            chk("decisions", 12, dcnt);
            rd_res; chk("result", pat, rr);
            rd(8'h00); chk("go cleared", c, rdv);
            rd(8'h05); chk("flags", 3, rdv);
        end
    endtask
    task automatic sev(input logic [3:0] m);
        @(posedge clk); compare_mode_field <= m; special_event <= 1'b1;
        #1 chk("timer clear", m == 4'hB, timer1_clear);
        @(posedge clk); special_event <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1; por_n <= 1'b1;
        rd(8'h00); chk("control", adc_seq_pkg::CONTROL_RST, rdv);
        rd(8'h01); chk("config", adc_seq_pkg::CONFIG_RST, rdv);
        rd(8'h02); chk("analog", adc_seq_pkg::ANALOG_RST, rdv);
        rd(8'h05); chk("flags", 0, rdv);
        rd(8'h07); chk("unmapped", 0, rdv);
        n = $random(seed);
        wr(8'h02, n[7:0] & 8'h3F); rd(8'h02); chk("analog", n[7:0] & 8'h3F, rdv);
        chk("pins", n[5:0], pin_analog_select);
        // Clock enable low freezes state
        @(posedge clk); clk_en <= 1'b0;
        wr(8'h02, 8'h00);
        @(posedge clk); clk_en <= 1'b1;
        rd(8'h02); chk("frozen", n[7:0] & 8'h3F, rdv);
        wr(8'h01, n[15:8]); rd(8'h01); chk("config", n[15:8], rdv);
        // Power and go in one write must not start
        wr(8'h00, 8'h05); rd(8'h00); chk("go dropped", 8'h01, rdv);
        for (int s = 0; s < 4; s++) conv(s[1:0], 0);
        wr(8'h00, 8'hC9); rd_res; chk("idle clear", pat, rr);
        rd(8'h05); chk("idle flags", 3, rdv);
        conv(2'b01, 5);
        wr(8'h00, 8'h09); wr(8'h05, 8'h02);
        sev(4'hB); wait_irq(n);
        rd_res; chk("event result", pat, rr);
        sev(4'hA);
        #1 chk("no start mode", 0, core_req.sample);
        wr(8'h00, 8'h00); sev(4'hB);
        #1 chk("no start", 0, core_req.sample);
        rd(8'h00); chk("go off", 0, rdv);
        // Reset in mid-conversion keeps the result pair
        wr(8'h00, 8'h49); wr(8'h00, 8'h4D);
        repeat (30) @(posedge clk);
        resetn <= 1'b0;
        @(posedge clk); resetn <= 1'b1;
        rd(8'h00); chk("control", 0, rdv);
        chk("irq", 0, conv_irq);
        rd_res; chk("kept result", pat, rr);
        complete_run;
    end
endmodule
